//--- design/pnlrh_core.v
`timescale 1ns/1ps
`include "pnlrh_regs.vh"

module pnlrh_core (
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone classic slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // machine timing, same clock
   input  wire        t0_i,
   input  wire        t24_i,
   input  wire        word_end_pulse_i,
   input  wire        instr_end_i,
   input  wire        halt_decode_i,
   input  wire        skip_pending_ff_i,
   input  wire        time_share_active_i,
   input  wire        parity_error_ff_i,
   // panel contacts, asynchronous
   input  wire        run_position_input_i,
   input  wire        step_position_input_i,
   input  wire        parity_override_continue_i,
   input  wire        fill_pushbutton_i,
   input  wire        selector_accumulator_i,
   input  wire        selector_extension_i,
   input  wire        selector_index_i,
   input  wire        selector_home_brk_i,
   input  wire        selector_accumulator_brk_i,
   input  wire        selector_extension_brk_i,
   input  wire        selector_index_brk_i,
   // serial register data
   input  wire        ir_bit23_i,
   input  wire        accumulator_serial_i,
   input  wire        extension_serial_i,
   input  wire        index_serial_i,
   // state and control outputs
   output reg         run_ff_o,
   output reg         halt_pending_ff_o,
   output reg         exchange_active_ff_o,
   output reg         display_sel_first_o,
   output reg         display_sel_second_o,
   output reg         opcode_load_enable_o,
   output reg         opcode_force_nop_o,
   output reg  [5:0]  opcode_nop_o,
   output reg         pc_shift_enable_o,
   output reg         ir_load_from_mdr_o,
   output reg         ir_shift_o,
   output reg         ir_bit0_o,
   output reg         accumulator_write_o,
   output reg         extension_write_o,
   output reg         index_write_o,
   output reg         reg_serial_o
);

   // two-flop synchroniser for panel contacts
   reg  [`PNLRH_SW_W-1:0] sw_meta;
   reg  [`PNLRH_SW_W-1:0] sw;
   wire [`PNLRH_SW_W-1:0] sw_raw;

   assign sw_raw = {selector_index_brk_i,
                    selector_extension_brk_i,
                    selector_accumulator_brk_i,
                    selector_home_brk_i,
                    selector_index_i,
                    selector_extension_i,
                    selector_accumulator_i,
                    fill_pushbutton_i,
                    parity_override_continue_i,
                    step_position_input_i,
                    run_position_input_i};

   // contacts bounce and are asynchronous: only sw is read downstream
   always @(posedge clk_i) begin
      if (rst_i) begin
         sw_meta <= `PNLRH_SW_RESET;
         sw      <= `PNLRH_SW_RESET;
      end else begin
         sw_meta <= sw_raw;
         sw      <= sw_meta;
      end
   end

   // software control
   reg         force_idle;

   wire        kg;
   wire        ks;
   wire        kp;
   wire        kf;
   wire        ka_mk;
   wire        kb_mk;
   wire        kx_mk;
   wire        kc_brk;
   wire        ka_brk;
   wire        kb_brk;
   wire        kx_brk;

   // forcing idle looks to the machine like the switch at Idle
   assign kg     = sw[`PNLRH_SW_RUN] & ~force_idle;
   assign ks     = sw[`PNLRH_SW_STEP] & ~force_idle;
   assign kp     = sw[`PNLRH_SW_PAR_CONT];
   assign kf     = sw[`PNLRH_SW_FILL];
   assign ka_mk  = sw[`PNLRH_SW_ACC_MK];
   assign kb_mk  = sw[`PNLRH_SW_EXT_MK];
   assign kx_mk  = sw[`PNLRH_SW_IDX_MK];
   assign kc_brk = sw[`PNLRH_SW_HOME_BRK];
   assign ka_brk = sw[`PNLRH_SW_ACC_BRK];
   assign kb_brk = sw[`PNLRH_SW_EXT_BRK];
   assign kx_brk = sw[`PNLRH_SW_IDX_BRK];

   // control state
   reg         run;
   reg         halt_pend;
   reg         exch;
   reg  [1:0]  disp;

   reg         next_run;
   reg         next_halt_pend;
   reg         next_exch;
   reg  [1:0]  next_disp;

   reg         set_halt;
   reg         clr_halt;
   reg         set_run;
   reg         clr_run;
   reg         set_exch;
   reg         displaced;
   reg  [1:0]  sel_code;
   reg         halt_by_instr;
   reg         halt_by_switch;
   reg         halt_by_parity;
   reg         exch_unlocked;
   reg         exch_wanted;
   reg         parity_lock;
   reg         next_parity_lock;

   // one strobe per register taking part in the exchange
   function pnlrh_is;
      input [1:0] code;
      input [1:0] want;
      begin
         pnlrh_is = (code == want);
      end
   endfunction

   // code of the register taking part in an exchange
   function [1:0] pnlrh_sel;
      input [1:0] cur;
      input       acc;
      input       ext;
      input       idx;
      begin
         if (cur != `PNLRH_DISP_HOME)
            pnlrh_sel = cur;
         else if (idx)
            pnlrh_sel = `PNLRH_DISP_IDX;
         else if (acc)
            pnlrh_sel = `PNLRH_DISP_ACC;
         else if (ext)
            pnlrh_sel = `PNLRH_DISP_EXT;
         else
            pnlrh_sel = `PNLRH_DISP_HOME;
      end
   endfunction

   always @* begin
      displaced = (disp != `PNLRH_DISP_HOME);
      sel_code  = pnlrh_sel(disp, ka_mk, kb_mk, kx_mk);

      // halt instruction acts at T0 of its execution
      halt_by_instr  = halt_decode_i & t0_i;
      // switch off Run: pending at T0 of the last cycle
      halt_by_switch = ~kg & run & t0_i & instr_end_i;
      // parity stop only with override at Halt, outside time share
      halt_by_parity = parity_error_ff_i & word_end_pulse_i & run
                     & ~kp & ~time_share_active_i;
      set_halt = halt_by_instr | halt_by_switch | halt_by_parity;
      // lock released only with the switch at Idle
      clr_halt = ~ks & ~kg & ~run & ~parity_error_ff_i & t24_i;

      set_run  = ~halt_pend & word_end_pulse_i & (ks | kg)
               & ~displaced & ~time_share_active_i & ~kf;
      clr_run  = word_end_pulse_i & instr_end_i & halt_pend
               & ~skip_pending_ff_i;

      // a parity lock is lifted for exchange by Continue, a halt lock not
      exch_unlocked = ~halt_pend | (parity_lock & kp);
      exch_wanted   = (~displaced & (ka_brk | kb_brk | kx_brk))
                    | (displaced & kc_brk)
                    | (displaced & (ks | kg));
      // break contacts start an exchange, only when fully halted
      set_exch = t24_i & ~time_share_active_i & ~run & exch_unlocked
               & ~kf & exch_wanted;

      next_halt_pend = halt_pend;
      if (set_halt)
         next_halt_pend = 1'b1;
      else if (clr_halt)
         next_halt_pend = 1'b0;

      // remembers that the present lock came from a parity stop
      next_parity_lock = parity_lock;
      if (halt_by_parity)
         next_parity_lock = 1'b1;
      else if (~next_halt_pend | halt_by_instr | halt_by_switch)
         next_parity_lock = 1'b0;

      // set and clear need opposite pending states, so never meet
      next_run = run;
      if (set_run)
         next_run = 1'b1;
      else if (clr_run)
         next_run = 1'b0;

      // clear first: one word only, even if the selector asks again
      next_exch = exch;
      if (exch & t0_i)
         next_exch = 1'b0;
      else if (set_exch)
         next_exch = 1'b1;

      // the end of an instruction wins over a late exchange
      next_disp = disp;
      if (run & word_end_pulse_i & instr_end_i)
         next_disp = `PNLRH_DISP_HOME;
      else if (exch & t0_i)
         next_disp = displaced ? `PNLRH_DISP_HOME : sel_code;
   end

   // run and pending together form the four panel states
   always @(posedge clk_i) begin
      if (rst_i) begin
         run       <= 1'b0;
         halt_pend <= 1'b0;
         exch      <= 1'b0;
         disp      <= `PNLRH_DISP_HOME;
         parity_lock <= 1'b0;
      end else begin
         run       <= next_run;
         halt_pend <= next_halt_pend;
         parity_lock <= next_parity_lock;
         exch      <= next_exch;
         disp      <= next_disp;
      end
   end

   // machine gating, registered from the next state so in step with it; exchange strobes one clock behind exch
   reg         sel_serial;

   // home selects nothing; zero keeps the IR input quiet
   always @* begin
      case (sel_code)
         `PNLRH_DISP_ACC: sel_serial = accumulator_serial_i;
         `PNLRH_DISP_EXT: sel_serial = extension_serial_i;
         `PNLRH_DISP_IDX: sel_serial = index_serial_i;
         default:         sel_serial = 1'b0;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         run_ff_o             <= 1'b0;
         halt_pending_ff_o    <= 1'b0;
         exchange_active_ff_o <= 1'b0;
         display_sel_first_o  <= 1'b0;
         display_sel_second_o <= 1'b0;
         opcode_load_enable_o <= 1'b0;
         opcode_force_nop_o   <= 1'b1;
         opcode_nop_o         <= `PNLRH_OPCODE_NOP;
         pc_shift_enable_o    <= 1'b0;
         ir_load_from_mdr_o   <= 1'b0;
         ir_shift_o           <= 1'b0;
         ir_bit0_o            <= 1'b0;
         accumulator_write_o  <= 1'b0;
         extension_write_o    <= 1'b0;
         index_write_o        <= 1'b0;
         reg_serial_o         <= 1'b0;
      end else begin
         run_ff_o             <= next_run;
         halt_pending_ff_o    <= next_halt_pend;
         exchange_active_ff_o <= next_exch;
         display_sel_first_o  <= next_disp[1];
         display_sel_second_o <= next_disp[0];
         opcode_load_enable_o <= next_run;
         opcode_force_nop_o   <= ~next_run;
         opcode_nop_o         <= `PNLRH_OPCODE_NOP;
         // pc also stops in time share, as the machine idles there
         pc_shift_enable_o    <= next_run & ~time_share_active_i;
         ir_load_from_mdr_o   <= next_run;
         ir_shift_o           <= exch;
         ir_bit0_o            <= exch & sel_serial;
         accumulator_write_o  <= exch & pnlrh_is(sel_code, `PNLRH_DISP_ACC);
         extension_write_o    <= exch & pnlrh_is(sel_code, `PNLRH_DISP_EXT);
         index_write_o        <= exch & pnlrh_is(sel_code, `PNLRH_DISP_IDX);
         reg_serial_o         <= ir_bit23_i;
      end
   end

   // wishbone slave: ack one clock after the strobe, always
   wire        wb_req;
   wire        wb_hit_ctrl;
   wire        wb_hit_stat;
   wire        wb_hit_sw;
   reg  [31:0] rd_mux;

   // the ack guard stops a held strobe from being taken twice
   assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_hit_ctrl = (wb_adr_i == `PNLRH_OFS_CTRL);
   assign wb_hit_stat = (wb_adr_i == `PNLRH_OFS_STATUS);
   assign wb_hit_sw   = (wb_adr_i == `PNLRH_OFS_SWITCH);

   always @* begin
      rd_mux = 32'h00000000;
      if (wb_hit_ctrl)
         rd_mux[`PNLRH_CTRL_FORCE_IDLE] = force_idle;
      else if (wb_hit_stat)
         rd_mux[`PNLRH_ST_W-1:0] = {disp[0], disp[1], exch, halt_pend, run};
      else if (wb_hit_sw)
         rd_mux[`PNLRH_SW_W-1:0] = sw;
   end

   // unmapped offsets are acknowledged, read zero, ignore writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h00000000;
         force_idle <= `PNLRH_CTRL_RESET;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req & ~wb_we_i)
            wb_dat_o <= rd_mux;
         // only byte lane 0 carries the control bit
         if (wb_req & wb_we_i & wb_hit_ctrl & wb_sel_i[0])
            force_idle <= wb_dat_i[`PNLRH_CTRL_FORCE_IDLE];
      end
   end

endmodule // pnlrh_core

//--- include/pnlrh_regs.vh
`ifndef PNLRH_REGS_VH
`define PNLRH_REGS_VH

// wishbone register byte offsets
`define PNLRH_ADDR_W          4
`define PNLRH_OFS_CTRL        4'h0
`define PNLRH_OFS_STATUS      4'h4
`define PNLRH_OFS_SWITCH      4'h8

// control register fields
`define PNLRH_CTRL_FORCE_IDLE 0
`define PNLRH_CTRL_RESET      1'h0

// status register fields
`define PNLRH_ST_RUN          0
`define PNLRH_ST_HALT         1
`define PNLRH_ST_EXCH         2
`define PNLRH_ST_DISP_FIRST   3
`define PNLRH_ST_DISP_SECOND  4
`define PNLRH_ST_W            5

// synchronised panel contact vector
`define PNLRH_SW_RUN          0
`define PNLRH_SW_STEP         1
`define PNLRH_SW_PAR_CONT     2
`define PNLRH_SW_FILL         3
`define PNLRH_SW_ACC_MK       4
`define PNLRH_SW_EXT_MK       5
`define PNLRH_SW_IDX_MK       6
`define PNLRH_SW_HOME_BRK     7
`define PNLRH_SW_ACC_BRK      8
`define PNLRH_SW_EXT_BRK      9
`define PNLRH_SW_IDX_BRK      10
`define PNLRH_SW_W            11
`define PNLRH_SW_RESET        11'h000

// display codes {first, second}
`define PNLRH_DISP_HOME       2'h0
`define PNLRH_DISP_EXT        2'h1
`define PNLRH_DISP_ACC        2'h2
`define PNLRH_DISP_IDX        2'h3

// no-operation opcode, octal 20
`define PNLRH_OPCODE_W        6
`define PNLRH_OPCODE_NOP      6'h10

`endif

//--- verif/pnlrh_checker.sv
`timescale 1ns/1ps
module pnlrh_checker (
   input wire clk_i,
   input wire rst_i,
   input wire t0_i,
   input wire t24_i,
   input wire word_end_pulse_i,
   input wire time_share_active_i,
   input wire parity_override_continue_i,
   input wire run_ff_o,
   input wire halt_pending_ff_o,
   input wire exchange_active_ff_o,
   input wire display_sel_first_o,
   input wire display_sel_second_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_run_set; $rose(run_ff_o) |-> $past(word_end_pulse_i && !halt_pending_ff_o
      && !display_sel_first_o && !display_sel_second_o); endproperty
   a_run_set: assert property (p_run_set) else $error("run set out of turn");
   property p_run_clr; $fell(run_ff_o) |-> $past(word_end_pulse_i && halt_pending_ff_o); endproperty
   a_run_clr: assert property (p_run_clr) else $error("run cleared out of turn");
   property p_halt_set; $rose(halt_pending_ff_o) |-> $past(t0_i || word_end_pulse_i); endproperty
   a_halt_set: assert property (p_halt_set) else $error("halt set off its pulse");
   property p_halt_clr; $fell(halt_pending_ff_o) |-> $past(t24_i && !run_ff_o); endproperty
   a_halt_clr: assert property (p_halt_clr) else $error("halt cleared wrongly");
   property p_exch_set; $rose(exchange_active_ff_o) |-> $past(t24_i && !run_ff_o
      && (!halt_pending_ff_o || parity_override_continue_i) && !time_share_active_i);
   endproperty
   a_exch_set: assert property (p_exch_set) else $error("exchange set wrongly");
   property p_exch_hold; exchange_active_ff_o && !t0_i |=> exchange_active_ff_o; endproperty
   a_exch_hold: assert property (p_exch_hold) else $error("exchange dropped early");
   property p_exch_end; exchange_active_ff_o && t0_i |=> !exchange_active_ff_o; endproperty
   a_exch_end: assert property (p_exch_end) else $error("exchange not ended");
   property p_disp; !$stable({display_sel_first_o, display_sel_second_o}) |->
      $past(t0_i && exchange_active_ff_o || word_end_pulse_i && run_ff_o); endproperty
   a_disp: assert property (p_disp) else $error("display bits moved");
endmodule // pnlrh_checker

bind pnlrh_core pnlrh_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .t0_i(t0_i),
   .t24_i(t24_i), .word_end_pulse_i(word_end_pulse_i),
   .time_share_active_i(time_share_active_i), .run_ff_o(run_ff_o),
   .parity_override_continue_i(parity_override_continue_i),
   .halt_pending_ff_o(halt_pending_ff_o), .exchange_active_ff_o(exchange_active_ff_o),
   .display_sel_first_o(display_sel_first_o), .display_sel_second_o(display_sel_second_o));

//--- verif/pnlrh_panel.sv
`timescale 1ns/1ps
module pnlrh_panel (
   input  wire       clk_i,
   input  wire [1:0] ctrl_i,
   input  wire [1:0] pos_i,
   output reg        run_o = 1'h0,
   output reg        step_o = 1'h0,
   output reg  [2:0] mk_o = 3'h0,
   output reg  [3:0] brk_o = 4'h1
);
   // knob codes follow the display code: 0 home, 1 ext, 2 acc, 3 index
   reg  [1:0] pos_q = 2'h0;
   wire [3:0] cur   = 4'h1 << pos_i;
   wire [3:0] old   = 4'h1 << pos_q;
   always @(posedge clk_i) begin
      pos_q  <= pos_i;
      run_o  <= (ctrl_i == 2'h1);
      step_o <= (ctrl_i == 2'h2);
      // make contacts overlap old and new position
      mk_o   <= cur[3:1] | old[3:1];
      // break contacts all open while the knob moves
      brk_o  <= (pos_i == pos_q) ? cur : 4'h0;
   end
endmodule // pnlrh_panel

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [4:0] cnt = 5'h0;
   logic [1:0] ctrl = 2'h0, pos = 2'h0;
   logic wb_ack_o, halt_decode_i = 1'h0, time_share_active_i = 1'h0;
   wire t24_i = (cnt == 5'h00), t0_i = (cnt == 5'h18), word_end_pulse_i = (cnt == 5'h19);
   wire ir_bit23_i = cnt[0], accumulator_serial_i = cnt[1];
   wire extension_serial_i = cnt[2], index_serial_i = cnt[3];
   wire instr_end_i = 1'h1, skip_pending_ff_i = 1'h0, fill_pushbutton_i = 1'h0;
   logic parity_error_ff_i = 1'h0, parity_override_continue_i = 1'h0;
   wire run_position_input_i, step_position_input_i, selector_accumulator_i;
   wire selector_extension_i, selector_index_i, selector_home_brk_i;
   wire selector_accumulator_brk_i, selector_extension_brk_i, selector_index_brk_i;
   logic run_ff_o, halt_pending_ff_o, exchange_active_ff_o, display_sel_first_o;
   logic display_sel_second_o, opcode_load_enable_o, opcode_force_nop_o, pc_shift_enable_o;
   logic [5:0] opcode_nop_o;
   logic ir_load_from_mdr_o, ir_shift_o, ir_bit0_o, accumulator_write_o;
   logic extension_write_o, index_write_o, reg_serial_o;
   int n_errors = 0, cmp_count = 0;
   always #2.5 clk_i = ~clk_i;
   // machine word: t24 first, t0 at bit 24, word end last
   always @(posedge clk_i) cnt <= (cnt == 5'h19) ? 5'h0 : cnt + 5'h1;
   pnlrh_core u_dut (.*);
   pnlrh_panel u_panel (.clk_i(clk_i), .ctrl_i(ctrl), .pos_i(pos),
      .run_o(run_position_input_i), .step_o(step_position_input_i),
      .mk_o({selector_index_i, selector_accumulator_i, selector_extension_i}),
      .brk_o({selector_index_brk_i, selector_accumulator_brk_i,
              selector_extension_brk_i, selector_home_brk_i}));
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (wb_ack_o !== 1'h1) begin
         chk(1'h0, "no bus ack");
         end_sim();
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'h0, a, 32'h0, q);
      chk(q === e, "read data");
   endtask
   task automatic words(input int k);
      int n;
      n = 0;
      repeat (k * 26) @(posedge clk_i);
      while (cnt !== 5'h19 && n < 30) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      #1;
   endtask
   task automatic set(input logic [1:0] c, input logic [1:0] p);
      @(posedge clk_i);
      ctrl <= c;
      pos <= p;
   endtask
   task automatic st(input logic [1:0] rh, input logic [1:0] d, input string m);
      chk({run_ff_o, halt_pending_ff_o} === rh && exchange_active_ff_o === 1'h0
          && {display_sel_first_o, display_sel_second_o} === d, m);
   endtask
   task automatic s_regs;
      logic [31:0] q;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h80);
      rd(4'hC, 32'h0);
      wb(1'h1, 4'hC, 32'h1, q);
      wb(1'h1, 4'h0, 32'h1, q);
      rd(4'h0, 32'h1);
      set(2'h1, 2'h0);
      words(2);
      st(2'h0, 2'h0, "forced idle ran");
      wb(1'h1, 4'h0, 32'h0, q);
   endtask
   task automatic s_run;
      words(2);
      st(2'h2, 2'h0, "not running");
      chk(opcode_load_enable_o === 1'h1 && pc_shift_enable_o === 1'h1
          && ir_load_from_mdr_o === 1'h1, "run gates");
      rd(4'h4, 32'h1);
      set(2'h0, 2'h0);
      words(2);
      st(2'h0, 2'h0, "idle stop");
      chk(opcode_force_nop_o === 1'h1 && opcode_nop_o === 6'h10 && pc_shift_enable_o === 1'h0
          && ir_load_from_mdr_o === 1'h0, "stop gates");
   endtask
   task automatic s_halt;
      set(2'h1, 2'h0);
      words(2);
      halt_decode_i <= 1'h1;
      words(1);
      halt_decode_i <= 1'h0;
      st(2'h1, 2'h0, "halt lock");
      set(2'h1, 2'h2);
      words(2);
      st(2'h1, 2'h0, "exchange while locked");
      set(2'h0, 2'h2);
      words(3);
      st(2'h0, 2'h2, "acc not shown");
   endtask
   task automatic s_disp;
      int n;
      n = 0;
      set(2'h0, 2'h0);
      while (exchange_active_ff_o !== 1'h1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      #1;
      chk(ir_shift_o === 1'h1 && accumulator_write_o === 1'h1, "no swap back");
      chk(reg_serial_o === ~ir_bit23_i, "serial out");
      words(2);
      st(2'h0, 2'h0, "not home");
      set(2'h0, 2'h3);
      words(3);
      st(2'h0, 2'h3, "index not shown");
      set(2'h1, 2'h3);
      words(3);
      st(2'h2, 2'h0, "run before home");
      set(2'h1, 2'h2);
      words(2);
      st(2'h2, 2'h0, "selector acted");
   endtask
   task automatic s_step;
      set(2'h0, 2'h0);
      words(3);
      st(2'h0, 2'h0, "idle again");
      set(2'h2, 2'h0);
      words(3);
      st(2'h1, 2'h0, "step held");
      set(2'h0, 2'h0);
      words(2);
      st(2'h0, 2'h0, "step released");
   endtask
   task automatic s_ts;
      time_share_active_i <= 1'h1;
      set(2'h0, 2'h2);
      words(2);
      st(2'h0, 2'h0, "exchange in time share");
      time_share_active_i <= 1'h0;
      words(3);
      st(2'h0, 2'h2, "acc not shown");
      set(2'h0, 2'h0);
      words(3);
      st(2'h0, 2'h0, "not home");
   endtask
   task automatic s_par;
      set(2'h1, 2'h0);
      words(2);
      parity_error_ff_i <= 1'h1;
      words(2);
      st(2'h1, 2'h0, "parity halt");
      set(2'h0, 2'h2);
      words(2);
      st(2'h1, 2'h0, "exchange after parity");
      parity_override_continue_i <= 1'h1;
      words(3);
      st(2'h1, 2'h2, "continue kept exchange off");
      parity_error_ff_i <= 1'h0;
      parity_override_continue_i <= 1'h0;
      set(2'h0, 2'h0);
      words(3);
      st(2'h0, 2'h0, "not home after parity");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      s_regs();
      s_run();
      s_halt();
      s_disp();
      s_step();
      s_ts();
      s_par();
      end_sim();
   end
endmodule // tb
